// [tb/host_link_model.sv]
`timescale 1ns/1ps
// Host end of the command link. It sends one command on request and,
// while feed is high, a valid command every 1000 cycles.
module host_link_model (
    input wire logic clk,
    input wire logic feed,
    input wire logic kick,
    input wire logic kick_ok,
    output logic link_cmd_done,
    output logic link_pec_ok
);
    logic [9:0] gap_cnt; // Cycles since the last fed command.
    logic fed_now; // A fed command goes out in this cycle.
    assign fed_now = feed && gap_cnt == 10'h3E7;
    initial begin
        gap_cnt = 10'h000;
        link_cmd_done = 1'b0;
        link_pec_ok = 1'b0;
    end
    // Outside a command the check flag toggles every cycle, so a design
    // that trusts the flag without the done pulse is caught.
    always @(posedge clk) begin
        gap_cnt <= (feed && !fed_now) ? gap_cnt + 10'h001 : 10'h000;
        link_cmd_done <= kick || fed_now;
        if (kick) begin
            link_pec_ok <= kick_ok;
        end else if (fed_now) begin
            link_pec_ok <= 1'b1;
        end else begin
            link_pec_ok <= ~link_pec_ok;
        end
    end
endmodule : host_link_model

// [tb/watchdog_discharge_timer_reset_tb.sv]
`timescale 1ns/1ps
`include "wdt_dt_defs.svh"
module watchdog_discharge_timer_reset_tb
    import wdt_dt_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pin = 1'b0; // Discharge timer enable pin.
    logic thermal = 1'b0;
    logic feed = 1'b0;
    logic kick = 1'b0;
    logic kick_ok = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, link_done, link_ok, wdt_out, wdt_oe;
    logic [47:0] cfg_a;
    logic [15:0] cfg_b;
    dev_state_type state;
    logic discharge_allow;
    group_reset_type group_reset;
    logic wdt_wire; // Open-drain pin with its external pull-up.
    int miscompares = 0;
    int samples_checked = 0;
    group_reset_type last_rst = '0; // Last nonzero group reset strobe.
    // The strobes last one cycle; catch them mid-cycle, where they stand.
    always @(negedge clk) begin
        if (group_reset != '0) begin
            last_rst <= group_reset;
        end
    end
    assign wdt_wire = wdt_oe ? wdt_out : 1'b1;
    // A tick of one clock keeps the long timer counts inside the run.
    watchdog_discharge_timer_reset #(.TICK_CYCLES(1)) dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_cmd_done(link_done), .link_pec_ok(link_ok),
        .discharge_timer_enable_pin(pin), .thermal_shutdown(thermal),
        .watchdog_output_pin_out(wdt_out),
        .watchdog_output_pin_oe(wdt_oe), .cfg_a(cfg_a), .cfg_b(cfg_b),
        .state(state), .discharge_allow(discharge_allow),
        .group_reset(group_reset));
    host_link_model host (.clk(clk), .feed(feed), .kick(kick),
        .kick_ok(kick_ok), .link_cmd_done(link_done),
        .link_pec_ok(link_ok));
    // Free-running clock.
    always #12.5 clk = ~clk;
    // Expected group A after a watchdog expiry with the timer running.
    function automatic logic [47:0] a_after_wdt(logic [47:0] a, logic m);
        return {a[47:32], m ? a[31:8] : 24'h000000, 8'h00};
    endfunction : a_after_wdt
    // Expected group A after a timeout before the watchdog expired.
    function automatic logic [47:0] a_after_to(logic [47:0] a, logic m);
        return {16'h0000, m ? 24'h000000 : a[31:8], a[7:0]};
    endfunction : a_after_to
    task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            miscompares++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask : rd
    // One host command; a bad check code should be ignored.
    task automatic kick_cmd(logic ok);
        @(posedge clk);
        kick <= 1'b1;
        kick_ok <= ok;
        @(posedge clk);
        kick <= 1'b0;
    endtask : kick_cmd
    // Bounded wait for the watchdog pin enable or the discharge flag.
    task automatic wait_low(logic which, int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if ((which ? discharge_allow : wdt_oe) === 1'b0) break;
        end
        if (n == lim) begin
            miscompares++;
            tally_and_finish();
        end
    endtask : wait_low
    // A measured time must land within ten cycles of its target.
    task automatic near(string name, int n, int target);
        check(name, 48'(n >= target - 10 && n <= target + 10), 48'h1);
    endtask : near
    // Hang guard.
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        int n, m, c;
        logic [31:0] r, lo, hi, b;
        logic e;
        void'($urandom(32'hF271F36B));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("cfg_a", cfg_a, `CFGA_RESET);
        check("cfg_b", 48'(cfg_b), 48'(`CFGB_RESET));
        check("state", 48'(state), 48'(standby));
        check("wdt_pin", 48'(wdt_wire), 48'h0);
        apb(1'b0, 8'h10, 32'h0000_0000, r, e);
        check("slverr", 48'(e), 48'h1);
        // Every timeout code reads back as its own bucket when fresh.
        pin <= 1'b1;
        repeat (5) @(posedge clk);
        for (c = 0; c < 16; c++) begin
            hi = {16'h0000, c[3:0], 12'($urandom())};
            wr(`OFS_CFGA_LO, $urandom());
            wr(`OFS_CFGA_HI, hi);
            rd(`OFS_CFGA_HI, r);
            check("bucket", 48'(r[15:12]), 48'(c[3:0]));
        end
        pin <= 1'b0;
        repeat (5) @(posedge clk);
        rd(`OFS_CFGA_HI, r);
        check("bucket_off", 48'(r[15:12]), 48'h0);
        // Overtemperature keeps only the mute bit of the groups.
        b = $urandom();
        wr(`OFS_CFGB, b);
        thermal <= 1'b1;
        repeat (6) @(posedge clk);
        check("hot_a", cfg_a, 48'h0);
        check("hot_b", 48'(cfg_b), 48'({6'h00, b[9], 9'h000}));
        check("hot_dis", 48'(discharge_allow), 48'h0);
        check("hot_rst", 48'(last_rst), 48'h02);
        thermal <= 1'b0;
        repeat (6) @(posedge clk);
        // Pin low with a nonzero code: expiry is the full reset.
        wr(`OFS_CFGA_LO, $urandom());
        wr(`OFS_CFGA_HI, {16'h0000, 4'h7, 12'($urandom())});
        wr(`OFS_CFGB, $urandom());
        kick_cmd(1'b1);
        repeat (2) @(posedge clk);
        check("active", 48'(state), 48'(active));
        repeat (998) @(posedge clk);
        kick_cmd(1'b0);
        wait_low(1'b0, 3000, n);
        near("wdt_time", n + 1002, 2000);
        repeat (3) @(posedge clk);
        check("wdt_pin", 48'(wdt_wire), 48'h1);
        check("sleep", 48'(state), 48'(sleep_st));
        check("wdt_a", cfg_a, 48'h0);
        check("wdt_b", 48'(cfg_b), 48'h0);
        check("wdt_dis", 48'(discharge_allow), 48'h0);
        check("wdt_rst", 48'(last_rst), 48'h1F);
        // Timer running, monitor off: expiry then timeout.
        pin <= 1'b1;
        repeat (5) @(posedge clk);
        b = $urandom() & 32'hFFFF_F7FF;
        wr(`OFS_CFGB, b);
        lo = $urandom();
        hi = {16'h0000, 4'h1, 12'($urandom())};
        wr(`OFS_CFGA_LO, lo);
        wr(`OFS_CFGA_HI, hi);
        wait_low(1'b0, 3000, n);
        near("wdt_time", n, 2000);
        repeat (3) @(posedge clk);
        check("tbal", 48'(state), 48'(timed_balancing));
        check("tbal_dis", 48'(discharge_allow), 48'h1);
        check("tbal_a", cfg_a, a_after_wdt({hi[15:0], lo}, b[11]));
        check("tbal_b", 48'(cfg_b), 48'({b[15:4], 4'h0}));
        check("tbal_rst", 48'(last_rst), 48'h02);
        wait_low(1'b1, 31000, m);
        near("to_time", n + m + 3, 30000);
        repeat (3) @(posedge clk);
        check("to_sleep", 48'(state), 48'(sleep_st));
        check("to_a", cfg_a, 48'h0);
        check("to_b", 48'(cfg_b), 48'h0);
        check("to_rst", 48'(last_rst), 48'h1F);
        // Monitor on, watchdog fed: the timeout alone ends discharge.
        b = $urandom() | 32'h0000_0800;
        wr(`OFS_CFGB, b);
        lo = $urandom();
        wr(`OFS_CFGA_LO, lo);
        wr(`OFS_CFGA_HI, {16'h0000, 4'h1, 12'($urandom())});
        feed <= 1'b1;
        wait_low(1'b1, 31000, m);
        near("fed_time", m, 30000);
        repeat (3) @(posedge clk);
        check("fed_pin", 48'(wdt_wire), 48'h0);
        check("fed_a", cfg_a, a_after_to({16'h0000, lo}, 1'b1));
        check("fed_b", 48'(cfg_b),
            48'({6'h00, b[9], 5'h00, b[3:0]}));
        check("fed_awake", 48'(state !== sleep_st), 48'h1);
        check("fed_rst", 48'(last_rst), 48'h1C);
        feed <= 1'b0;
        tally_and_finish();
    end
endmodule : watchdog_discharge_timer_reset_tb

// [verilog/watchdog_discharge_timer_reset.sv]
// Functional notes
// - Watchdog expires after two seconds without command.
// - Watchdog always on; valid command restarts it.
// - On expiry release open-drain watchdog pin.
// - Timer needs enable pin high, nonzero code.
// - Code selects duration from half to 120 minutes.
// - Group A read returns remaining-time bucket.
// - Only group A write restarts discharge timer.
// - Running timer keeps switches on at expiry.
// - Timer off: expiry resets A, B, S control.
// - Idle timeout: sleep, full group resets.
// - Expiry while running: timed balancing, partial resets.
// - Timeout before expiry: discharge off, partial resets.
// - Timeout after expiry: sleep, full resets.
// - Timeout during A write keeps new data.
// - Timeout during A/B read still resets.
// - Timeout during S read resets S bits.
// - Power cycle: standby, defaults, discharge allowed.
// - Thermal: discharge off, reset A, B except mute bit, COMM.
`timescale 1ns/1ps
`include "wdt_dt_defs.svh"
module watchdog_discharge_timer_reset
    import wdt_dt_pkg::*;
#(
    // Clock cycles per millisecond tick; shorten in simulation.
    parameter int unsigned TICK_CYCLES =
        `TICK_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_cmd_done,
    input wire logic link_pec_ok,
    input wire logic discharge_timer_enable_pin,
    input wire logic thermal_shutdown,
    output logic watchdog_output_pin_out,
    output logic watchdog_output_pin_oe,
    output logic [47:0] cfg_a,
    output logic [15:0] cfg_b,
    output dev_state_type state,
    output logic discharge_allow,
    output group_reset_type group_reset
);
    // Watchdog limit in ticks.
    localparam logic [10:0] WDT_TICKS = 11'(`WDT_TIME_MS);
    // Group A reset image, sliced per byte range where parts reset.
    localparam logic [47:0] A_RST_IMG = `CFGA_RESET;

    // Duration of each timeout code in ticks (milliseconds).
    function automatic logic [22:0] dur_ms(input logic [3:0] code);
        logic [7:0] half;
        half = 8'h00;
        unique case (code)
            4'h0: half = 8'h00;
            4'h1: half = 8'h01;
            4'h2: half = 8'h02;
            4'h3: half = 8'h04;
            4'h4: half = 8'h06;
            4'h5: half = 8'h08;
            4'h6: half = 8'h0A;
            4'h7: half = 8'h14;
            4'h8: half = 8'h1E;
            4'h9: half = 8'h28;
            4'hA: half = 8'h3C;
            4'hB: half = 8'h50;
            4'hC: half = 8'h78;
            4'hD: half = 8'h96;
            4'hE: half = 8'hB4;
            4'hF: half = 8'hF0;
        endcase
        return 23'(half * `HALF_MIN_MS);
    endfunction : dur_ms

    // Smallest code whose duration covers the time left.
    function automatic logic [3:0] bucket(input logic [22:0] left);
        logic [3:0] res;
        res = 4'h0;
        for (int k = 15; k >= 1; k--) begin
            if (left != 23'h0 && left <= dur_ms(4'(k))) begin
                res = 4'(k);
            end
        end
        return res;
    endfunction : bucket

    // Pin synchronisers: three stages, change taken when 2 and 3 agree.
    logic [2:0] enpin_sync;
    logic [2:0] thsd_sync;
    logic enpin_q; // Filtered enable pin.
    logic thsd_q; // Filtered thermal flag.
    logic thsd_d; // Last filtered thermal flag, for edge.

    // Timebase and timers.
    logic [15:0] tick_cnt;
    logic tick;
    logic [10:0] wdt_cnt;
    logic wdt_expired;
    logic running;
    logic [22:0] run_ms;
    logic dt_done; // Timed out; switches off until a group A write.
    logic [47:0] next_cfg_a;
    logic [15:0] next_cfg_b;

    // Bus decode, kept as named wires.
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_alo = paddr == `OFS_CFGA_LO;
    wire hit_ahi = paddr == `OFS_CFGA_HI;
    wire hit_b = paddr == `OFS_CFGB;
    wire hit_st = paddr == `OFS_STATUS;
    wire mapped = hit_alo || hit_ahi || hit_b || hit_st;
    wire wr_alo = access && pwrite && hit_alo;
    wire wr_ahi = access && pwrite && hit_ahi;
    wire wr_b = access && pwrite && hit_b;
    wire wra = wr_alo || wr_ahi;

    // A bus write to a configuration group is a valid command.
    wire link_ok = link_cmd_done && link_pec_ok;
    wire valid_cmd = link_ok || wra || wr_b;
    wire monitor_on = cfg_b[`MONITOR_EN_BIT];
    wire [3:0] new_code = next_cfg_a[`TIMEOUT_CODE_MSB:`TIMEOUT_CODE_LSB];

    // Timer events.
    wire wdt_fire = tick && !wdt_expired && !valid_cmd &&
        wdt_cnt == WDT_TICKS - 11'h001;
    wire dt_fire = running && tick && run_ms == 23'h000001;
    // A simultaneous expiry and timeout counts as the full case.
    wire full_rst = (wdt_fire && (!running || dt_fire)) ||
        (dt_fire && wdt_expired);
    wire ext_bal = wdt_fire && running && !dt_fire;
    wire dt_part = dt_fire && !wdt_expired && !wdt_fire;
    wire thsd_edge = thsd_q && !thsd_d;

    // Synchronise and filter the two pins; stage 1 feeds stage 2 only.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enpin_sync <= 3'h0;
            thsd_sync <= 3'h0;
        end else begin
            enpin_sync <= {enpin_sync[1:0], discharge_timer_enable_pin};
            thsd_sync <= {thsd_sync[1:0], thermal_shutdown};
        end
    end

    // Accept a pin change only once the last two stages agree.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enpin_q <= 1'b0;
            thsd_q <= 1'b0;
            thsd_d <= 1'b0;
        end else begin
            if (enpin_sync[1] == enpin_sync[2]) begin
                enpin_q <= enpin_sync[2];
            end
            if (thsd_sync[1] == thsd_sync[2]) begin
                thsd_q <= thsd_sync[2];
            end
            thsd_d <= thsd_q;
        end
    end

    // Shared millisecond tick for both timers.
    assign tick = tick_cnt == 16'(TICK_CYCLES - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt <= 16'h0000;
        end else if (tick) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    // Watchdog: cannot be disabled; a valid command restarts it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_cnt <= 11'h000;
            wdt_expired <= 1'b0;
        end else if (valid_cmd) begin
            wdt_cnt <= 11'h000;
            wdt_expired <= 1'b0;
        end else if (wdt_fire) begin
            wdt_expired <= 1'b1;
        end else if (tick && !wdt_expired) begin
            wdt_cnt <= wdt_cnt + 11'h001;
        end
    end

    // Open-drain pin: pulled low until expiry, then released.
    assign watchdog_output_pin_out = 1'b0;
    assign watchdog_output_pin_oe = !wdt_expired;

    // Discharge timer. Only a group A write reloads it; the write wins
    // over a timeout in the same cycle so the new setting survives.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            running <= 1'b0;
            run_ms <= 23'h000000;
        end else if (!enpin_q || thsd_q) begin
            running <= 1'b0;
            run_ms <= 23'h000000;
        end else if (wra) begin
            running <= new_code != 4'h0;
            run_ms <= dur_ms(new_code);
        end else if (dt_fire) begin
            running <= 1'b0;
            run_ms <= 23'h000000;
        end else if (running && tick) begin
            run_ms <= run_ms - 23'h000001;
        end
    end

    // Timeout latch: the switches stay off after a timeout until the
    // host writes group A again; a write in the same cycle wins, as above.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dt_done <= 1'b0;
        end else if (wra) begin
            dt_done <= 1'b0;
        end else if (dt_fire) begin
            dt_done <= 1'b1;
        end
    end

    // Group A next value: event resets first, then a bus write on top.
    always_comb begin
        next_cfg_a = cfg_a;
        if (thsd_edge || full_rst) begin
            next_cfg_a = `CFGA_RESET;
        end else begin
            if (ext_bal) begin
                next_cfg_a[7:0] = A_RST_IMG[7:0];
                if (!monitor_on) begin
                    next_cfg_a[31:8] = A_RST_IMG[31:8];
                end
            end
            if (dt_part) begin
                next_cfg_a[47:32] = A_RST_IMG[47:32];
                if (monitor_on) begin
                    next_cfg_a[31:8] = A_RST_IMG[31:8];
                end
            end
        end
        if (wr_alo) begin
            next_cfg_a[31:0] = pwdata;
        end
        if (wr_ahi) begin
            next_cfg_a[47:32] = pwdata[15:0];
        end
    end

    // Group B next value; the mute bit survives all but a full reset.
    always_comb begin
        next_cfg_b = cfg_b;
        if (full_rst) begin
            next_cfg_b = `CFGB_RESET;
        end else begin
            if (thsd_edge) begin
                next_cfg_b = `CFGB_RESET;
                next_cfg_b[`MUTE_BIT] = cfg_b[`MUTE_BIT];
            end
            if (ext_bal) begin
                next_cfg_b[3:0] = 4'h0;
            end
            if (dt_part) begin
                next_cfg_b[7:4] = 4'h0;
                next_cfg_b[15:8] = 8'h00;
                next_cfg_b[`MUTE_BIT] = cfg_b[`MUTE_BIT];
            end
        end
        if (wr_b) begin
            next_cfg_b = pwdata[15:0];
        end
    end

    // Configuration storage; power-on reset restores defaults.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_a <= `CFGA_RESET;
            cfg_b <= `CFGB_RESET;
        end else begin
            cfg_a <= next_cfg_a;
            cfg_b <= next_cfg_b;
        end
    end

    // Device state: sleep on full reset, timed balancing on expiry with the timer running.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= standby;
        end else if (full_rst) begin
            state <= sleep_st;
        end else if (ext_bal) begin
            state <= timed_balancing;
        end else if (valid_cmd) begin
            state <= active;
        end
    end

    // Switches stay on after expiry only while the timer runs.
    assign discharge_allow = !thsd_q && state != sleep_st && !dt_done &&
        (running || !wdt_expired);

    // Strobes to the S control, PWM and COMM groups held elsewhere.
    // Thermal shutdown leaves the S control group untouched.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            group_reset <= '0;
        end else begin
            group_reset.s_ctrl <= full_rst || dt_part;
            group_reset.pwm <= full_rst || dt_part;
            group_reset.pwm_s <= full_rst || dt_part;
            group_reset.comm <= full_rst || ext_bal || thsd_edge;
            group_reset.fsm <= full_rst;
        end
    end

    // Read image: the code field shows the time left, not what was set.
    wire [3:0] left_code = running ? bucket(run_ms) : 4'h0;
    wire [31:0] rd_ahi = {16'h0000, left_code,
        cfg_a[`TIMEOUT_CODE_LSB-1:32]};
    wire [31:0] rd_st = {26'h0, state, thsd_q, enpin_q, running,
        wdt_expired};
    wire [31:0] rd_mux = hit_alo ? cfg_a[31:0] :
        hit_ahi ? rd_ahi :
        hit_b ? {16'h0000, cfg_b} :
        hit_st ? rd_st : 32'h0000_0000;

    // Read data is captured in the setup cycle, so a timeout landing
    // between setup and access may show stale bytes; this is allowed.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wdt_kick_a: assert property (valid_cmd |=>
        !wdt_expired && wdt_cnt == 11'h000)
        else $error("watchdog not restarted by a valid command");
    wdt_expire_a: assert property (tick && !wdt_expired &&
        !valid_cmd && wdt_cnt == WDT_TICKS - 11'h001 |=> wdt_expired)
        else $error("watchdog missed its limit");
    wdt_pin_a: assert property (wdt_fire |=>
        !watchdog_output_pin_oe ##1
        (!watchdog_output_pin_oe || $past(valid_cmd)))
        else $error("watchdog pin not released");
    dt_enable_a: assert property (!enpin_q |=> !running)
        else $error("timer runs with enable pin low");
    dt_load_a: assert property (wra && enpin_q && !thsd_q &&
        new_code != 4'h0 |=> running &&
        run_ms == dur_ms($past(new_code)))
        else $error("timer loaded with wrong duration");
    dt_hold_a: assert property (running && enpin_q && !thsd_q &&
        !wra && link_ok && run_ms > 23'h000001 |=>
        run_ms == $past(run_ms) - 23'($past(tick)))
        else $error("timer restarted by other command");
    dt_off_a: assert property (dt_part && !wra |=>
        !discharge_allow && !running)
        else $error("discharge left on after timeout");
    bal_keep_a: assert property (ext_bal |=>
        state == timed_balancing && discharge_allow)
        else $error("switches dropped in timed balancing");
    sleep_full_a: assert property (full_rst |=>
        state == sleep_st && !discharge_allow && group_reset.fsm)
        else $error("full reset did not reach sleep");
    thsd_off_a: assert property (thsd_edge && !wra |=>
        cfg_a == `CFGA_RESET && group_reset.comm && !discharge_allow)
        else $error("thermal shutdown reset missing");
    left_zero_a: assert property (!running |-> left_code == 4'h0)
        else $error("idle timer reads nonzero");
endmodule : watchdog_discharge_timer_reset

// [verilog/wdt_dt_defs.svh]
`ifndef WDT_DT_DEFS_SVH
`define WDT_DT_DEFS_SVH
// APB word offsets (byte addresses).
`define OFS_CFGA_LO 8'h00
`define OFS_CFGA_HI 8'h04
`define OFS_CFGB 8'h08
`define OFS_STATUS 8'h0C
// Field positions inside the 48-bit group A and 16-bit group B images.
`define TIMEOUT_CODE_LSB 44
`define TIMEOUT_CODE_MSB 47
`define MONITOR_EN_BIT 11
`define MUTE_BIT 9
// Reset images of the configuration groups.
`define CFGA_RESET 48'h0000_0000_0000
`define CFGB_RESET 16'h0000
// Timing: one timebase tick is one millisecond at a 25 ns clock.
`define CLK_PERIOD_NS 25
`define TICK_TIME_NS 1000000
`define WDT_TIME_MS 2000
`define HALF_MIN_MS 30000
`endif

// [verilog/wdt_dt_pkg.sv]
package wdt_dt_pkg;
    // Operating state seen by the rest of the device.
    typedef enum logic [1:0] {
        standby,
        active,
        timed_balancing,
        sleep_st
    } dev_state_type;
    // One-cycle reset strobes for register groups held elsewhere.
    typedef struct packed {
        logic s_ctrl;
        logic pwm;
        logic pwm_s;
        logic comm;
        logic fsm;
    } group_reset_type;
endpackage : wdt_dt_pkg
